// ---- comm_master_model.sv ----
`timescale 1ns/1ps
module comm_master_model (
   // clock
   input wire core_clk,
   // request side
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_addr,
   output logic [15:0] reg_wdata,
   // answer side
   input wire [15:0] reg_rdata,
   input wire reg_ack,
   input wire reg_err
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'hffff;
      reg_wdata = 16'hffff;
   end
   // one word per request; level is taken every edge, so held for one edge only
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
         output logic [15:0] q, output logic e, output logic k);
      @(negedge core_clk);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      q = reg_rdata;
      e = reg_err;
      k = reg_ack;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // released lines show the inverse, never a stale copy
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // comm_master_model

// ---- drive_comm_control_map.v ----
// Operation
// - codes 1-4 start forward/reverse run or jog
// - codes 5-8 stop, coast, fault reset, end jog
// - 2001H holds link frequency setpoint
// - 2002H/2003H hold loop reference and feedback
// - 2004H holds signed torque setpoint
// - 2005H/2006H hold forward and reverse limits
// - 2007H/2008H hold motoring and braking torque limits
// - control word bits 1:0 select motor
// - bit2 allows switchover, bit3 clears energy
// - bit4 pre-excitation, bit5 DC braking
// - 200AH holds ten-bit virtual input pattern
// - 200BH holds four-bit virtual output pattern
// - 200CH holds separated output voltage setpoint
// - 200DH/200EH hold signed analog output setpoints
// - 2100H reports drive state code
// - 2101H reports ready, motor, motor type
// - 2101H reports overload alarm, command source
// - 2101H reports torque, position, control method
// - 2102H fault code, 2103H identification code
// - 3000H-3002H report frequencies and bus voltage
// - read-only registers refuse writes
`timescale 1ns/1ps
`include "drive_comm_map.vh"
module drive_comm_control_map #(
   parameter [15:0] IDENT_CODE = 16'h0a5a, // arbitrary value
   parameter [15:0] MAX_FREQUENCY = 16'd5000
) (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   input wire clk_en,
   // register port from the frame handler
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata,
   output reg reg_ack,
   output reg reg_err,
   // drive state inputs from the controller core
   input wire is_running,
   input wire is_reverse,
   input wire is_faulted,
   input wire is_power_off,
   input wire is_pre_exciting,
   input wire ready_to_run,
   input wire [1:0] active_motor,
   input wire synchronous_motor,
   input wire overload_alarm,
   input wire [1:0] command_source,
   input wire torque_mode,
   input wire position_mode,
   input wire [1:0] control_method,
   input wire [15:0] fault_code,
   input wire [15:0] running_frequency,
   input wire [15:0] set_frequency,
   input wire [15:0] bus_voltage,
   // command pulses
   output reg run_forward,
   output reg run_reverse,
   output reg jog_forward,
   output reg jog_reverse,
   output reg stop_normal,
   output reg stop_coast,
   output reg fault_reset,
   output reg jog_end,
   output reg energy_clear,
   // setpoint levels
   output wire [15:0] frequency_setpoint,
   output wire [15:0] loop_reference,
   output wire [15:0] loop_feedback,
   output wire [15:0] torque_setpoint,
   output wire [15:0] forward_freq_limit,
   output wire [15:0] reverse_freq_limit,
   output wire [15:0] motoring_torque_limit,
   output wire [15:0] braking_torque_limit,
   output wire [15:0] voltage_setpoint,
   output wire [15:0] analog_out_one_setpoint,
   output wire [15:0] analog_out_two_setpoint,
   // special control word fields
   output reg [1:0] motor_select,
   output reg switchover_enable,
   output reg pre_excite_enable,
   output reg dc_brake_enable,
   // virtual terminals
   output reg [9:0] virtual_inputs,
   output reg relay_output_one,
   output reg relay_output_two,
   output reg transistor_output
);

reg [15:0] run_command;
reg [15:0] special_control_word;
reg [3:0] virtual_outputs;
reg [15:0] drive_state_word;
reg [15:0] drive_condition_word;
reg [15:0] next_rdata;
reg next_err;
reg wr_ok;
wire wr_accept;

// signed bound checks on two's complement values
function in_signed;
   input [15:0] value;
   input [15:0] bound;
   begin
      if (value[15])
         in_signed = ((~value) + 16'h0001) <= bound;
      else
         in_signed = value <= bound;
   end
endfunction

// state word priority: fault over power-off over pre-excitation over run
always @* begin
   if (is_faulted)
      drive_state_word = `STATE_FAULT;
   else if (is_power_off)
      drive_state_word = `STATE_POWER_OFF;
   else if (is_pre_exciting)
      drive_state_word = `STATE_PRE_EXCITE;
   else if (is_running && is_reverse)
      drive_state_word = `STATE_REV;
   else if (is_running)
      drive_state_word = `STATE_FWD;
   else
      drive_state_word = `STATE_STOPPED;
end

always @* begin
   drive_condition_word = `RESET_ZERO;
   drive_condition_word[`COND_READY_BIT] = ready_to_run;
   drive_condition_word[`COND_MOTOR_MSB:`COND_MOTOR_LSB] = active_motor;
   drive_condition_word[`COND_SYNC_BIT] = synchronous_motor;
   drive_condition_word[`COND_OVERLOAD_BIT] = overload_alarm;
   drive_condition_word[`COND_SOURCE_MSB:`COND_SOURCE_LSB] = command_source;
   drive_condition_word[`COND_TORQUE_BIT] = torque_mode;
   drive_condition_word[`COND_POSITION_BIT] = position_mode;
   drive_condition_word[`COND_METHOD_MSB:`COND_METHOD_LSB] = control_method;
end

// out-of-range values are refused whole rather than clipped
always @* begin
   case (reg_addr)
      `ADDR_RUN_COMMAND:
         wr_ok = reg_wdata >= `CMD_RUN_FWD && reg_wdata <= `CMD_JOG_END;
      `ADDR_FREQUENCY_SETPOINT, `ADDR_FORWARD_FREQ_LIMIT, `ADDR_REVERSE_FREQ_LIMIT:
         wr_ok = reg_wdata <= MAX_FREQUENCY;
      `ADDR_LOOP_REFERENCE, `ADDR_LOOP_FEEDBACK, `ADDR_VOLTAGE_SETPOINT:
         wr_ok = reg_wdata <= `LIMIT_PERCENT;
      `ADDR_TORQUE_SETPOINT:
         wr_ok = in_signed(reg_wdata, `LIMIT_TORQUE);
      `ADDR_MOTORING_TORQUE_LIMIT, `ADDR_BRAKING_TORQUE_LIMIT:
         wr_ok = reg_wdata <= `LIMIT_TORQUE;
      `ADDR_SPECIAL_CONTROL_WORD:
         wr_ok = 1'b1;
      `ADDR_VIRTUAL_INPUTS:
         wr_ok = reg_wdata <= `LIMIT_VIRTUAL_INPUTS;
      `ADDR_VIRTUAL_OUTPUTS:
         wr_ok = reg_wdata <= `LIMIT_VIRTUAL_OUTPUTS;
      `ADDR_ANALOG_OUT_ONE, `ADDR_ANALOG_OUT_TWO:
         wr_ok = in_signed(reg_wdata, `LIMIT_PERCENT);
      default:
         wr_ok = 1'b0;
   endcase
end

always @* begin
   next_err = 1'b0;
   case (reg_addr)
      `ADDR_RUN_COMMAND: next_rdata = run_command;
      `ADDR_FREQUENCY_SETPOINT: next_rdata = frequency_setpoint;
      `ADDR_LOOP_REFERENCE: next_rdata = loop_reference;
      `ADDR_LOOP_FEEDBACK: next_rdata = loop_feedback;
      `ADDR_TORQUE_SETPOINT: next_rdata = torque_setpoint;
      `ADDR_FORWARD_FREQ_LIMIT: next_rdata = forward_freq_limit;
      `ADDR_REVERSE_FREQ_LIMIT: next_rdata = reverse_freq_limit;
      `ADDR_MOTORING_TORQUE_LIMIT: next_rdata = motoring_torque_limit;
      `ADDR_BRAKING_TORQUE_LIMIT: next_rdata = braking_torque_limit;
      `ADDR_SPECIAL_CONTROL_WORD: next_rdata = special_control_word;
      `ADDR_VIRTUAL_INPUTS: next_rdata = {6'h00, virtual_inputs};
      `ADDR_VIRTUAL_OUTPUTS: next_rdata = {12'h000, virtual_outputs};
      `ADDR_VOLTAGE_SETPOINT: next_rdata = voltage_setpoint;
      `ADDR_ANALOG_OUT_ONE: next_rdata = analog_out_one_setpoint;
      `ADDR_ANALOG_OUT_TWO: next_rdata = analog_out_two_setpoint;
      `ADDR_DRIVE_STATE_WORD: next_rdata = drive_state_word;
      `ADDR_DRIVE_CONDITION_WORD: next_rdata = drive_condition_word;
      `ADDR_FAULT_NUMBER: next_rdata = fault_code;
      `ADDR_DEVICE_IDENT: next_rdata = IDENT_CODE;
      `ADDR_ACTUAL_FREQUENCY: next_rdata = running_frequency;
      `ADDR_TARGET_FREQUENCY: next_rdata = set_frequency;
      `ADDR_DC_LINK_VOLTAGE: next_rdata = bus_voltage;
      default: begin
         next_rdata = `RESET_ZERO;
         next_err = 1'b1;
      end
   endcase
end

always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      reg_rdata <= `RESET_ZERO;
      reg_ack <= 1'b0;
      reg_err <= 1'b0;
      run_command <= `RESET_ZERO;
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
      jog_forward <= 1'b0;
      jog_reverse <= 1'b0;
      stop_normal <= 1'b0;
      stop_coast <= 1'b0;
      fault_reset <= 1'b0;
      jog_end <= 1'b0;
      energy_clear <= 1'b0;
      special_control_word <= `RESET_ZERO;
      motor_select <= 2'b00;
      switchover_enable <= 1'b0;
      pre_excite_enable <= 1'b0;
      dc_brake_enable <= 1'b0;
      virtual_inputs <= 10'h000;
      virtual_outputs <= 4'h0;
      relay_output_one <= 1'b0;
      relay_output_two <= 1'b0;
      transistor_output <= 1'b0;
   end else if (clk_en) begin
      reg_ack <= reg_wr | reg_rd;
      reg_err <= 1'b0;
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
      jog_forward <= 1'b0;
      jog_reverse <= 1'b0;
      stop_normal <= 1'b0;
      stop_coast <= 1'b0;
      fault_reset <= 1'b0;
      jog_end <= 1'b0;
      energy_clear <= 1'b0;
      if (reg_rd && !reg_wr) begin
         reg_rdata <= next_rdata;
         reg_err <= next_err;
      end
      if (reg_wr && !wr_ok) begin
         reg_err <= 1'b1;
      end
      if (reg_wr && wr_ok) begin
         reg_rdata <= reg_wdata;
         case (reg_addr)
            `ADDR_RUN_COMMAND: begin
               run_command <= reg_wdata;
               case (reg_wdata)
                  `CMD_RUN_FWD: run_forward <= 1'b1;
                  `CMD_RUN_REV: run_reverse <= 1'b1;
                  `CMD_JOG_FWD: jog_forward <= 1'b1;
                  `CMD_JOG_REV: jog_reverse <= 1'b1;
                  `CMD_STOP: stop_normal <= 1'b1;
                  `CMD_COAST: stop_coast <= 1'b1;
                  `CMD_FAULT_RESET: fault_reset <= 1'b1;
                  `CMD_JOG_END: jog_end <= 1'b1;
                  default: jog_end <= 1'b0;
               endcase
            end
            `ADDR_SPECIAL_CONTROL_WORD: begin
               special_control_word <= reg_wdata & `SCW_USED_MASK;
               motor_select <= reg_wdata[`SCW_MOTOR_MSB:`SCW_MOTOR_LSB];
               switchover_enable <= reg_wdata[`SCW_SWITCHOVER_BIT];
               // clear is a pulse; data is kept while the bit stays low
               energy_clear <= reg_wdata[`SCW_ENERGY_CLEAR_BIT];
               pre_excite_enable <= reg_wdata[`SCW_PRE_EXCITE_BIT];
               dc_brake_enable <= reg_wdata[`SCW_DC_BRAKE_BIT];
            end
            `ADDR_VIRTUAL_INPUTS: begin
               virtual_inputs <= reg_wdata[9:0];
               virtual_inputs[`VIN_RESERVED_BIT] <= 1'b0;
            end
            `ADDR_VIRTUAL_OUTPUTS: begin
               virtual_outputs <= reg_wdata[3:0] & 4'hd;
               transistor_output <= reg_wdata[`VOUT_TRANSISTOR_BIT];
               relay_output_one <= reg_wdata[`VOUT_RELAY_ONE_BIT];
               relay_output_two <= reg_wdata[`VOUT_RELAY_TWO_BIT];
            end
            // setpoint words load in their own instances below
            default: reg_err <= 1'b0;
         endcase
      end
   end
end

// only range-checked writes reach the setpoint words
assign wr_accept = reg_wr && wr_ok;

setpoint_word #(.ADDR(`ADDR_FREQUENCY_SETPOINT)) u_frequency_setpoint (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(frequency_setpoint));

setpoint_word #(.ADDR(`ADDR_LOOP_REFERENCE)) u_loop_reference (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(loop_reference));

setpoint_word #(.ADDR(`ADDR_LOOP_FEEDBACK)) u_loop_feedback (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(loop_feedback));

setpoint_word #(.ADDR(`ADDR_TORQUE_SETPOINT)) u_torque_setpoint (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(torque_setpoint));

setpoint_word #(.ADDR(`ADDR_FORWARD_FREQ_LIMIT)) u_forward_freq_limit (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(forward_freq_limit));

setpoint_word #(.ADDR(`ADDR_REVERSE_FREQ_LIMIT)) u_reverse_freq_limit (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(reverse_freq_limit));

setpoint_word #(.ADDR(`ADDR_MOTORING_TORQUE_LIMIT)) u_motoring_torque_limit (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(motoring_torque_limit));

setpoint_word #(.ADDR(`ADDR_BRAKING_TORQUE_LIMIT)) u_braking_torque_limit (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(braking_torque_limit));

setpoint_word #(.ADDR(`ADDR_VOLTAGE_SETPOINT)) u_voltage_setpoint (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(voltage_setpoint));

setpoint_word #(.ADDR(`ADDR_ANALOG_OUT_ONE)) u_analog_out_one_setpoint (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(analog_out_one_setpoint));

setpoint_word #(.ADDR(`ADDR_ANALOG_OUT_TWO)) u_analog_out_two_setpoint (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
   .load(wr_accept), .addr(reg_addr), .wdata(reg_wdata),
   .value(analog_out_two_setpoint));

endmodule // drive_comm_control_map

// one link-writable setpoint word; the caller checks the range
module setpoint_word #(
   parameter [15:0] ADDR = 16'h0000
) (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   input wire clk_en,
   // accepted write from the register port
   input wire load,
   input wire [15:0] addr,
   input wire [15:0] wdata,
   // stored word
   output reg [15:0] value
);

// a write to any other word leaves this one untouched
always @(posedge core_clk or negedge nrst) begin
   if (!nrst) begin
      value <= `RESET_ZERO;
   end else if (clk_en && load && addr == ADDR) begin
      value <= wdata;
   end
end

endmodule // setpoint_word

// ---- drive_comm_control_map_props.sv ----
`timescale 1ns/1ps
module drive_comm_control_map_props #(
   parameter [15:0] MAX_FREQUENCY = 16'd5000
) (
   // clock and reset
   input wire core_clk,
   input wire nrst,
   input wire clk_en,
   // register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata,
   input wire reg_ack,
   input wire reg_err,
   // watched state and outputs
   input wire is_faulted,
   input wire run_forward,
   input wire stop_normal,
   input wire jog_end,
   input wire energy_clear,
   input wire [15:0] frequency_setpoint,
   input wire [9:0] virtual_inputs
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   wire wr_go = clk_en && reg_wr;
   AST_ACK: assert property ((clk_en && (reg_wr || reg_rd)) |=> reg_ack)
      else $error("no acknowledge after request");
   AST_RUN_FWD: assert property ((wr_go && reg_addr == 16'h2000 && reg_wdata == 16'h0001)
      |=> run_forward && reg_rdata == 16'h0001)
      else $error("forward run not issued");
   AST_STOP: assert property ((wr_go && reg_addr == 16'h2000 && reg_wdata == 16'h0005)
      |=> stop_normal && !run_forward)
      else $error("normal stop not issued");
   AST_JOG_END: assert property ((wr_go && reg_addr == 16'h2000 && reg_wdata == 16'h0008)
      |=> jog_end)
      else $error("jog end not issued");
   AST_RO_WR: assert property ((wr_go && reg_addr[15:8] != 8'h20) |=> reg_err && reg_ack)
      else $error("write to read-only area not refused");
   AST_FREQ_SET: assert property ((wr_go && reg_addr == 16'h2001 && reg_wdata <= MAX_FREQUENCY)
      |=> frequency_setpoint == $past(reg_wdata))
      else $error("frequency setpoint not stored");
   AST_FREQ_HOLD: assert property ((clk_en && !reg_wr) |=> $stable(frequency_setpoint))
      else $error("frequency setpoint moved without write");
   AST_ENERGY: assert property ((wr_go && reg_addr == 16'h2009 && reg_wdata[3])
      |=> energy_clear)
      else $error("energy clear not pulsed");
   AST_STATE_FAULT: assert property ((clk_en && reg_rd && !reg_wr && reg_addr == 16'h2100
      && is_faulted) |=> reg_rdata == 16'h0004 && !reg_err)
      else $error("fault state not reported");
   AST_VIN_RSVD: assert property (virtual_inputs[5] == 1'b0)
      else $error("reserved virtual input set");
endmodule // drive_comm_control_map_props

bind drive_comm_control_map drive_comm_control_map_props #(.MAX_FREQUENCY(MAX_FREQUENCY)) u_props (
   .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
   .reg_err(reg_err), .is_faulted(is_faulted), .run_forward(run_forward),
   .stop_normal(stop_normal), .jog_end(jog_end), .energy_clear(energy_clear),
   .frequency_setpoint(frequency_setpoint), .virtual_inputs(virtual_inputs));

// ---- drive_comm_control_map_tb_top.sv ----
`timescale 1ns/1ps
module drive_comm_control_map_tb_top;
   localparam [15:0] IDENT = 16'h0c3c; // arbitrary value
   localparam [15:0] FMAX = 16'd5000;
   logic core_clk, nrst, clk_en;
   logic [15:0] fq;
   logic fe, fk;
   logic [4:0] st;
   logic [10:0] cond;
   wire reg_wr, reg_rd, reg_ack, reg_err;
   wire [15:0] reg_addr, reg_wdata, reg_rdata, freq, torq;
   wire [8:0] pv;
   wire [1:0] msel;
   wire [9:0] vin;
   wire sw, pre, dcb, ro1, ro2, tro;
   int failures = 0;
   int cmp_count = 0;
   logic [15:0] wv [14] = '{16'h1388, 16'h03e8, 16'h0000, 16'hf448, 16'h04d2, 16'h1388,
      16'h0bb8, 16'h0001, 16'hff35, 16'h03ff, 16'h000f, 16'h03e8, 16'hfc18, 16'h03e8};
   logic [15:0] rv [14] = '{16'h1388, 16'h03e8, 16'h0000, 16'hf448, 16'h04d2, 16'h1388,
      16'h0bb8, 16'h0001, 16'h0035, 16'h03df, 16'h000d, 16'h03e8, 16'hfc18, 16'h03e8};
   logic [15:0] bv [14] = '{16'h1389, 16'h03e9, 16'hffff, 16'h0bb9, 16'h1389, 16'hffff,
      16'h0bb9, 16'hffff, 16'h0000, 16'h0400, 16'h0010, 16'h03e9, 16'h03e9, 16'hfc17};
   logic [4:0] sv [6] = '{5'h00, 5'h10, 5'h18, 5'h11, 5'h13, 5'h1f};
   logic [15:0] ev [6] = '{16'h3, 16'h1, 16'h2, 16'h6, 16'h5, 16'h4};
   logic [10:0] cv [4] = '{11'h001, 11'h332, 11'h4c9, 11'h7eb};

   comm_master_model u_comm_master_model (.core_clk(core_clk), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_err(reg_err));
   drive_comm_control_map #(.IDENT_CODE(IDENT), .MAX_FREQUENCY(FMAX)) u_drive_comm_control_map (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_err(reg_err), .is_running(st[4]), .is_reverse(st[3]), .is_faulted(st[2]),
      .is_power_off(st[1]), .is_pre_exciting(st[0]), .ready_to_run(cond[0]),
      .active_motor(cond[2:1]), .synchronous_motor(cond[3]), .overload_alarm(cond[4]),
      .command_source(cond[6:5]), .torque_mode(cond[7]), .position_mode(cond[8]),
      .control_method(cond[10:9]), .fault_code(16'h0017), .running_frequency(16'h1234),
      .set_frequency(16'h1388), .bus_voltage(16'h1f40), .run_forward(pv[0]),
      .run_reverse(pv[1]), .jog_forward(pv[2]), .jog_reverse(pv[3]), .stop_normal(pv[4]),
      .stop_coast(pv[5]), .fault_reset(pv[6]), .jog_end(pv[7]), .energy_clear(pv[8]),
      .frequency_setpoint(freq), .loop_reference(), .loop_feedback(), .torque_setpoint(torq),
      .forward_freq_limit(), .reverse_freq_limit(), .motoring_torque_limit(),
      .braking_torque_limit(), .voltage_setpoint(), .analog_out_one_setpoint(),
      .analog_out_two_setpoint(), .motor_select(msel), .switchover_enable(sw),
      .pre_excite_enable(pre), .dc_brake_enable(dcb), .virtual_inputs(vin),
      .relay_output_one(ro1), .relay_output_two(ro2), .transistor_output(tro));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic acc(input logic w, input logic [15:0] a, d, x, input logic ee);
      logic [15:0] q;
      logic e, k;
      u_comm_master_model.access(w, a, d, q, e, k);
      chk("ack", 16'h1, {15'h0, k});
      chk("err", {15'h0, ee}, {15'h0, e});
      if (!(w && ee)) chk("data", x, q);
   endtask

   task automatic summarize;
      $display("Comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      summarize();
   end

   initial begin
      nrst = 1'b0;
      clk_en = 1'b1;
      st = 5'h00;
      cond = 11'h000;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      for (int a = 16'h2000; a <= 16'h200e; a++) acc(0, a[15:0], 0, 0, 0);
      for (int c = 1; c <= 8; c++) begin
         acc(1, 16'h2000, c[15:0], c[15:0], 0);
         chk("pulse", 16'h1 << (c - 1), {7'h0, pv});
         acc(0, 16'h2000, 0, c[15:0], 0);
         chk("pulse", 16'h0, {7'h0, pv});
      end
      acc(1, 16'h2000, 16'h0009, 0, 1);
      acc(1, 16'h2000, 16'h0000, 0, 1);
      for (int i = 0; i < 14; i++) begin
         acc(1, 16'h2001 + i[15:0], wv[i], wv[i], 0);
         if (i != 8) acc(1, 16'h2001 + i[15:0], bv[i], 0, 1);
         acc(0, 16'h2001 + i[15:0], 0, rv[i], 0);
      end
      chk("freq", FMAX, freq);
      chk("torque", 16'hf448, torq);
      chk("control", 16'h001d, {11'h0, dcb, pre, sw, msel});
      chk("vin", 16'h03df, {6'h0, vin});
      chk("vout", 16'h000d, {12'h0, ro2, ro1, 1'b0, tro});
      acc(1, 16'h2009, 16'h0008, 16'h0008, 0);
      chk("pulse", 16'h0100, {7'h0, pv});
      chk("control", 16'h0000, {11'h0, dcb, pre, sw, msel});
      acc(1, 16'h2100, 16'h0001, 0, 1);
      acc(1, 16'h3000, 16'h0001, 0, 1);
      acc(0, 16'h2010, 0, 16'h0000, 1);
      for (int i = 0; i < 6; i++) begin
         st = sv[i];
         acc(0, 16'h2100, 0, ev[i], 0);
      end
      for (int i = 0; i < 4; i++) begin
         cond = cv[i];
         acc(0, 16'h2101, 0, {4'h0, cv[i][10:7], 1'b0, cv[i][6:0]}, 0);
      end
      acc(0, 16'h2102, 0, 16'h0017, 0);
      acc(0, 16'h2103, 0, IDENT, 0);
      acc(0, 16'h3000, 0, 16'h1234, 0);
      acc(0, 16'h3001, 0, 16'h1388, 0);
      acc(0, 16'h3002, 0, 16'h1f40, 0);
      // let the last ack drop before freezing, or it would stay frozen high
      @(negedge core_clk);
      clk_en = 1'b0;
      u_comm_master_model.access(1, 16'h2001, 16'h0064, fq, fe, fk);
      clk_en = 1'b1;
      chk("frozen ack", 16'h0, {15'h0, fk});
      chk("freq", FMAX, freq);
      summarize();
   end
endmodule // drive_comm_control_map_tb_top

// ---- drive_comm_map.vh ----
`ifndef DRIVE_COMM_MAP_VH
`define DRIVE_COMM_MAP_VH
// register addresses
`define ADDR_RUN_COMMAND 16'h2000
`define ADDR_FREQUENCY_SETPOINT 16'h2001
`define ADDR_LOOP_REFERENCE 16'h2002
`define ADDR_LOOP_FEEDBACK 16'h2003
`define ADDR_TORQUE_SETPOINT 16'h2004
`define ADDR_FORWARD_FREQ_LIMIT 16'h2005
`define ADDR_REVERSE_FREQ_LIMIT 16'h2006
`define ADDR_MOTORING_TORQUE_LIMIT 16'h2007
`define ADDR_BRAKING_TORQUE_LIMIT 16'h2008
`define ADDR_SPECIAL_CONTROL_WORD 16'h2009
`define ADDR_VIRTUAL_INPUTS 16'h200a
`define ADDR_VIRTUAL_OUTPUTS 16'h200b
`define ADDR_VOLTAGE_SETPOINT 16'h200c
`define ADDR_ANALOG_OUT_ONE 16'h200d
`define ADDR_ANALOG_OUT_TWO 16'h200e
`define ADDR_DRIVE_STATE_WORD 16'h2100
`define ADDR_DRIVE_CONDITION_WORD 16'h2101
`define ADDR_FAULT_NUMBER 16'h2102
`define ADDR_DEVICE_IDENT 16'h2103
`define ADDR_ACTUAL_FREQUENCY 16'h3000
`define ADDR_TARGET_FREQUENCY 16'h3001
`define ADDR_DC_LINK_VOLTAGE 16'h3002
// run command codes
`define CMD_RUN_FWD 16'h0001
`define CMD_RUN_REV 16'h0002
`define CMD_JOG_FWD 16'h0003
`define CMD_JOG_REV 16'h0004
`define CMD_STOP 16'h0005
`define CMD_COAST 16'h0006
`define CMD_FAULT_RESET 16'h0007
`define CMD_JOG_END 16'h0008
// state word codes
`define STATE_FWD 16'h0001
`define STATE_REV 16'h0002
`define STATE_STOPPED 16'h0003
`define STATE_FAULT 16'h0004
`define STATE_POWER_OFF 16'h0005
`define STATE_PRE_EXCITE 16'h0006
// value limits
`define LIMIT_PERCENT 16'd1000
`define LIMIT_TORQUE 16'd3000
`define LIMIT_VIRTUAL_INPUTS 16'h03ff
`define LIMIT_VIRTUAL_OUTPUTS 16'h000f
// special control word fields
`define SCW_MOTOR_LSB 0
`define SCW_MOTOR_MSB 1
`define SCW_SWITCHOVER_BIT 2
`define SCW_ENERGY_CLEAR_BIT 3
`define SCW_PRE_EXCITE_BIT 4
`define SCW_DC_BRAKE_BIT 5
`define SCW_USED_MASK 16'h003f
// virtual terminal fields
`define VIN_RESERVED_BIT 5
`define VOUT_TRANSISTOR_BIT 0
`define VOUT_RESERVED_BIT 1
`define VOUT_RELAY_ONE_BIT 2
`define VOUT_RELAY_TWO_BIT 3
// condition word fields
`define COND_READY_BIT 0
`define COND_MOTOR_LSB 1
`define COND_MOTOR_MSB 2
`define COND_SYNC_BIT 3
`define COND_OVERLOAD_BIT 4
`define COND_SOURCE_LSB 5
`define COND_SOURCE_MSB 6
`define COND_TORQUE_BIT 8
`define COND_POSITION_BIT 9
`define COND_METHOD_LSB 10
`define COND_METHOD_MSB 11
// reset values
`define RESET_ZERO 16'h0000
`endif
